// ==== logic/amp_prot_pkg.sv ====
package amp_prot_pkg;
  // ----------------------------------------
  // register offsets (byte subaddresses)
  // ----------------------------------------
  localparam logic [7:0] FAULT_STATUS_OFS  = 8'h02;
  localparam logic [7:0] FAULT_PIN_CFG_OFS = 8'h05;
  localparam logic [7:0] OUT_SHDN_CFG_OFS  = 8'h19;
  localparam logic [7:0] OUT_MUX_CFG_OFS   = 8'h25;
  localparam logic [7:0] ADDR_UNLOCK_OFS   = 8'hF8;
  localparam logic [7:0] NEW_ADDR_OFS      = 8'hF9;
  // ----------------------------------------
  // field positions and values
  // ----------------------------------------
  localparam int          STICKY_FAULT_BIT = 1;
  localparam int          PIN_OUT_EN_BIT   = 0;
  localparam logic [31:0] UNLOCK_PATTERN   = 32'hF9A5A5A5;
  localparam logic [6:0]  ADDR_PIN_HIGH    = 7'h1B; // 8-bit form 0x36
  localparam logic [6:0]  ADDR_PIN_LOW     = 7'h1A; // 8-bit form 0x34
  localparam logic [7:0]  SHDN_CFG_RESET   = 8'h00;
  localparam logic [31:0] MUX_CFG_RESET    = 32'h00000000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ            = 25_000_000;
  localparam int LIMIT_CYCLES_MAX  = 8;  // limited switching cycles before latch
endpackage : amp_prot_pkg

// ==== logic/prot_status_if.sv ====
interface prot_status_if;
  logic       shutdown;
  logic [3:0] bridge_off;
  logic       any_fault;
  modport src (output shutdown, output bridge_off, output any_fault);
  modport dst (input shutdown, input bridge_off, input any_fault);
endinterface : prot_status_if

// ==== logic/prot_core.sv ====
// latching overcurrent shutdown core; thermal and undervoltage shutdown follow their inputs unlatched
module prot_core #(
  parameter int LIMIT_MAX = amp_prot_pkg::LIMIT_CYCLES_MAX
) (
  // clocking
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // synchronised conditions
  input  wire logic [3:0] oc_det,
  input  wire logic       cycle_start,
  input  wire logic       parallel_bridge_select,
  input  wire logic       overtemp_error,
  input  wire logic       uv_any,
  input  wire logic       overvolt,
  input  wire logic       por_done,
  // results
  output logic [3:0]      limit_off,
  prot_status_if.src      st
);
  import amp_prot_pkg::*;

  logic       oc_latch, next_oc_latch;
  logic [7:0] olp_cnt, next_olp_cnt;
  logic       oc_seen, next_oc_seen;
  logic [3:0] next_limit_off;
  logic [3:0] paired;

  // ----------------------------------------
  // per-cycle limiting and overload count
  // ----------------------------------------
  always_comb begin
    paired = oc_det;
    if (parallel_bridge_select) begin
      paired = {{2{|oc_det[3:2]}}, {2{|oc_det[1:0]}}};
    end
    next_limit_off = paired;
    next_oc_seen   = oc_seen | (|oc_det);
    next_olp_cnt   = olp_cnt;
    next_oc_latch  = oc_latch;
    if (cycle_start) begin
      next_limit_off = 4'h0;                        // release at new cycle
      next_oc_seen   = |oc_det;
      if (oc_seen) begin
        if (olp_cnt < 8'(LIMIT_MAX)) next_olp_cnt = olp_cnt + 8'h01;
      end else begin
        next_olp_cnt = 8'h00;
      end
    end
    if (olp_cnt >= 8'(LIMIT_MAX)) next_oc_latch = 1'b1;
    // latch releases at a cycle start once the short is gone, or while power-on reset holds
    if (oc_latch && !(|oc_det) && cycle_start) begin
      next_oc_latch = 1'b0;
      next_olp_cnt  = 8'h00;
    end
    if (!por_done) begin
      next_olp_cnt  = 8'h00;
      next_oc_latch = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      oc_latch  <= 1'b0;
      olp_cnt   <= 8'h00;
      oc_seen   <= 1'b0;
      limit_off <= 4'h0;
    end else if (clk_en) begin
      oc_latch  <= next_oc_latch;
      olp_cnt   <= next_olp_cnt;
      oc_seen   <= next_oc_seen;
      limit_off <= next_limit_off;
    end
  end

  // whole stage goes hi-z on any shutdown source
  assign st.shutdown   = oc_latch | overtemp_error | uv_any | overvolt | !por_done;
  assign st.bridge_off = {4{st.shutdown}} | limit_off;
  assign st.any_fault  = oc_latch | overtemp_error | uv_any | overvolt;
endmodule : prot_core

// ==== logic/amp_fault_protection_ctrl.sv ====
// Contract
// - at power-up sample address pin: high gives 0x36, low gives 0x34
// - after unlock, low byte written to new_bus_address becomes the new address
// - parallel bridge select pairs A/B and C/D turnoff on overcurrent
// - current detector fire limits current that switching cycle only
// - persistent overcurrent latches hi-z shutdown until condition clears
// - latched overcurrent from any bridge shuts down all four half-bridges
// - over-temperature sets hi-z and fault pin low, recovers automatically
// - undervoltage on analog or stage supply sets hi-z, fault low
// - power-on reset clears overload counter, releases when supplies good
// - address pin becomes fault output only after bit0 of fault_pin_config set
// - fault pin low for any shutdown fault in output mode
// - sticky fault copy in bit1 of fault_status, cleared by host write
// - fault pin high in output mode while no fault present
module amp_fault_protection_ctrl (
  // clocking
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // register access from the serial control engine
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic [6:0]       bus_address,
  // address / fault pin
  input  wire logic        addr_fault_in,
  output logic             addr_fault_out,
  output logic             addr_fault_oe,
  // power stage conditions
  input  wire logic        parallel_bridge_select,
  input  wire logic [3:0]  oc_det,
  input  wire logic        cycle_start,
  input  wire logic        overtemp_error,
  input  wire logic        analog_supply_uv,
  input  wire logic        stage_supply_uv,
  input  wire logic        overvolt,
  input  wire logic        stage_supply_good,
  input  wire logic        analog_supply_good,
  // power stage controls
  output logic [3:0]       bridge_hiz,
  output logic [7:0]       output_shutdown_cfg,
  output logic [31:0]      output_mux_cfg
);
  import amp_prot_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] raw_in, meta, synced;
  assign raw_in = {addr_fault_in, parallel_bridge_select, oc_det, cycle_start,
                   overtemp_error, analog_supply_uv, stage_supply_uv, overvolt,
                   stage_supply_good & analog_supply_good};

  // two stages per pin, generated for every asynchronous input
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          meta[g]   <= 1'b0;
          synced[g] <= 1'b0;
        end else if (clk_en) begin
          meta[g]   <= raw_in[g];
          synced[g] <= meta[g];
        end
      end
    end
  endgenerate

  logic       s_pin, s_pbs, s_cyc, s_ote, s_auv, s_puv, s_ov, s_pgood;
  logic [3:0] s_oc;
  assign {s_pin, s_pbs, s_oc, s_cyc, s_ote, s_auv, s_puv, s_ov, s_pgood} = synced;

  // ----------------------------------------
  // protection core
  // ----------------------------------------
  prot_status_if st ();
  logic [3:0] limit_off;
  logic       por_done, next_por_done;

  prot_core u_core (
    .ref_clk                (ref_clk),
    .rst                    (rst),
    .clk_en                 (clk_en),
    .oc_det                 (s_oc),
    .cycle_start            (s_cyc),
    .parallel_bridge_select (s_pbs),
    .overtemp_error         (s_ote),
    .uv_any                 (s_auv | s_puv),
    .overvolt               (s_ov),
    .por_done               (por_done),
    .limit_off              (limit_off),
    .st                     (st.src)
  );

  // ----------------------------------------
  // address strap sequencer
  // ----------------------------------------
  // synchroniser needs two edges, so strap is taken on the third after reset
  typedef enum logic [1:0] {
    STRAP_FILL0 = 2'b00,
    STRAP_FILL1 = 2'b01,
    STRAP_TAKE  = 2'b10,
    STRAP_DONE  = 2'b11
  } strap_state_t;
  strap_state_t strap_state, next_strap_state;
  logic         strap_done;

  // one step per enabled edge, then parked until the next reset
  always_comb begin
    next_strap_state = strap_state;
    case (strap_state)
      STRAP_FILL0: next_strap_state = STRAP_FILL1;
      STRAP_FILL1: next_strap_state = STRAP_TAKE;
      STRAP_TAKE:  next_strap_state = STRAP_DONE;
      STRAP_DONE:  next_strap_state = STRAP_DONE;
      default:     next_strap_state = STRAP_FILL0;
    endcase
  end

  // strap state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strap_state <= STRAP_FILL0;
    end else if (clk_en) begin
      strap_state <= next_strap_state;
    end
  end

  // pin may only turn to an output after its strap level was taken
  assign strap_done = (strap_state == STRAP_DONE);

  // ----------------------------------------
  // register file and address change
  // ----------------------------------------
  logic [6:0]  next_bus_address;
  logic        unlocked, next_unlocked;
  logic        pin_out_en, next_pin_out_en;
  logic        sticky, next_sticky;
  logic [7:0]  next_shdn;
  logic [31:0] next_mux, next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  always_comb begin
    next_bus_address = bus_address;
    next_unlocked    = unlocked;
    next_pin_out_en  = pin_out_en;
    next_sticky      = sticky;
    next_shdn        = output_shutdown_cfg;
    next_mux         = output_mux_cfg;
    next_rdata       = reg_rdata;
    next_por_done    = s_pgood;
    if (strap_state == STRAP_TAKE) begin
      next_bus_address = s_pin ? ADDR_PIN_HIGH : ADDR_PIN_LOW;
    end
    if (reg_wr) begin
      if (hit(reg_addr, ADDR_UNLOCK_OFS)) begin
        next_unlocked = (reg_wdata == UNLOCK_PATTERN);
      end
      if (hit(reg_addr, NEW_ADDR_OFS) && unlocked) begin
        next_bus_address = reg_wdata[7:1];
        next_unlocked    = 1'b0;
      end
      if (hit(reg_addr, FAULT_PIN_CFG_OFS)) begin
        next_pin_out_en = reg_wdata[PIN_OUT_EN_BIT];
      end
      if (hit(reg_addr, FAULT_STATUS_OFS)) begin
        next_sticky = 1'b0;
      end
      if (hit(reg_addr, OUT_SHDN_CFG_OFS)) next_shdn = reg_wdata[7:0];
      if (hit(reg_addr, OUT_MUX_CFG_OFS))  next_mux  = reg_wdata;
    end
    // a new fault in the clearing cycle still sets the bit
    if (st.any_fault) next_sticky = 1'b1;
    if (reg_rd) begin
      case (reg_addr)
        FAULT_STATUS_OFS:  next_rdata = {30'h0, sticky, 1'b0};
        FAULT_PIN_CFG_OFS: next_rdata = {31'h0, pin_out_en};
        OUT_SHDN_CFG_OFS:  next_rdata = {24'h0, output_shutdown_cfg};
        OUT_MUX_CFG_OFS:   next_rdata = output_mux_cfg;
        default:           next_rdata = 32'h0;  // write-only and unmapped read zero
      endcase
    end
  end

  // register stage only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_address         <= ADDR_PIN_LOW;
      unlocked            <= 1'b0;
      pin_out_en          <= 1'b0;
      sticky              <= 1'b0;
      output_shutdown_cfg <= SHDN_CFG_RESET;
      output_mux_cfg      <= MUX_CFG_RESET;
      reg_rdata           <= 32'h0;
      por_done            <= 1'b0;
    end else if (clk_en) begin
      bus_address         <= next_bus_address;
      unlocked            <= next_unlocked;
      pin_out_en          <= next_pin_out_en;
      sticky              <= next_sticky;
      output_shutdown_cfg <= next_shdn;
      output_mux_cfg      <= next_mux;
      reg_rdata           <= next_rdata;
      por_done            <= next_por_done;
    end
  end

  // ----------------------------------------
  // pin and stage outputs
  // ----------------------------------------
  // pin stays an input until software enables output mode
  assign addr_fault_oe  = pin_out_en & strap_done;
  assign addr_fault_out = ~st.any_fault;
  assign bridge_hiz     = st.bridge_off;
endmodule : amp_fault_protection_ctrl

// ==== verif/amp_prot_checker.sv ====
// watches the top ports only; every fault input is held for several cycles before a claim
module amp_prot_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // register strobes
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic [6:0]  bus_address,
  // pin and power stage
  input wire logic        addr_fault_out,
  input wire logic        addr_fault_oe,
  input wire logic        overtemp_error,
  input wire logic        analog_supply_uv,
  input wire logic        stage_supply_uv,
  input wire logic        overvolt,
  input wire logic [3:0]  bridge_hiz
);
  timeunit 1ns;
  timeprecision 1ns;
  import amp_prot_pkg::*;
  logic        unlocked, next_unlocked;
  logic [31:0] last_wdata, next_last_wdata;
  // shadow of the unlock state, a bad pattern or one address write drops it
  always_comb begin
    next_unlocked = unlocked;
    next_last_wdata = reg_wdata;
    if (reg_wr && reg_addr == ADDR_UNLOCK_OFS) next_unlocked = (reg_wdata == UNLOCK_PATTERN);
    else if (reg_wr && reg_addr == NEW_ADDR_OFS) next_unlocked = 1'b0;
    if (rst) next_unlocked = 1'b0;
  end
  always_ff @(posedge ref_clk) begin
    unlocked <= next_unlocked;
    last_wdata <= next_last_wdata;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_hiz_overtemp: assert property (overtemp_error [*5] |-> bridge_hiz == 4'hF)
    else $error("outputs not hi-z during overtemperature");
  a_hiz_undervolt: assert property (
    (analog_supply_uv || stage_supply_uv) [*5] |-> bridge_hiz == 4'hF)
    else $error("outputs not hi-z during undervoltage");
  a_fault_pin_low: assert property (overvolt [*5] ##0 addr_fault_oe |-> !addr_fault_out)
    else $error("fault pin not low during overvoltage");
  a_sticky_set: assert property (
    (overtemp_error || analog_supply_uv || stage_supply_uv || overvolt) [*5] ##1
    (reg_rd && reg_addr == FAULT_STATUS_OFS) |-> ##2 reg_rdata[1])
    else $error("sticky fault bit not reported");
  a_pin_stays_input: assert property (
    !addr_fault_oe && !(reg_wr && reg_addr == FAULT_PIN_CFG_OFS) |=> !addr_fault_oe)
    else $error("fault pin drove without enable write");
  a_pin_enable: assert property (
    reg_wr && reg_addr == FAULT_PIN_CFG_OFS |=> addr_fault_oe == last_wdata[0])
    else $error("fault pin enable does not follow bit 0");
  a_addr_refused: assert property (
    reg_wr && reg_addr == NEW_ADDR_OFS && !unlocked |=> $stable(bus_address))
    else $error("address changed without unlock");
  a_addr_change: assert property (
    reg_wr && reg_addr == NEW_ADDR_OFS && unlocked |=> bus_address == last_wdata[7:1])
    else $error("new address not taken");
endmodule : amp_prot_checker
bind amp_fault_protection_ctrl amp_prot_checker chk_u (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .bus_address, .addr_fault_out, .addr_fault_oe, .overtemp_error,
  .analog_supply_uv, .stage_supply_uv, .overvolt, .bridge_hiz);

// ==== verif/host_model.sv ====
// control host: turns one bench request into a single-cycle register strobe
module host_model (
  // clock
  input wire logic         ref_clk,
  // request from the bench
  input wire logic         go,
  input wire logic         go_wr,
  input wire logic [7:0]   go_addr,
  input wire logic [31:0]  go_data,
  // strobes toward the device
  output logic             reg_wr = 1'b0,
  output logic             reg_rd = 1'b0,
  output logic [7:0]       reg_addr = 8'h00,
  output logic [31:0]      reg_wdata = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle address and data flip so a stale value is never mistaken for a request
  always @(posedge ref_clk) begin
    reg_wr <= go && go_wr;
    reg_rd <= go && !go_wr;
    reg_addr <= go ? go_addr : ~reg_addr;
    reg_wdata <= go ? go_data : ~reg_wdata;
  end
endmodule : host_model

// ==== verif/amp_fault_protection_ctrl_tb.sv ====
module amp_fault_protection_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import amp_prot_pkg::*;
  logic ref_clk = 0, rst = 1, go = 0, go_wr = 0, pin = 1, pbs = 0, cyc = 0;
  logic ot = 0, auv = 0, suv = 0, ov = 0, good = 0;
  logic [3:0] oc = 4'h0;
  logic [7:0] go_addr = 8'h00;
  logic [31:0] go_data = 32'h0, seed = 32'hD, v;
  wire logic reg_wr, reg_rd, fout, foe;
  wire logic [7:0] reg_addr, shdn;
  wire logic [31:0] reg_wdata, rdata, mux;
  wire logic [6:0] bus_address;
  wire logic [3:0] hiz;
  int bad_count = 0, compares = 0;
  always #20 ref_clk = ~ref_clk;
  host_model host_u (.ref_clk, .go, .go_wr, .go_addr, .go_data, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata);
  // the shared pin reads back the device level while it drives
  amp_fault_protection_ctrl dut_u (.ref_clk, .rst, .clk_en(1'b1), .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata(rdata), .bus_address, .addr_fault_in(foe ? fout : pin),
    .addr_fault_out(fout), .addr_fault_oe(foe), .parallel_bridge_select(pbs), .oc_det(oc),
    .cycle_start(cyc), .overtemp_error(ot), .analog_supply_uv(auv), .stage_supply_uv(suv),
    .overvolt(ov), .stage_supply_good(good), .analog_supply_good(good), .bridge_hiz(hiz),
    .output_shutdown_cfg(shdn), .output_mux_cfg(mux));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // strapped address expected for a pin level
  function logic [6:0] strap_addr(input logic lvl);
    return lvl ? ADDR_PIN_HIGH : ADDR_PIN_LOW;
  endfunction : strap_addr
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt
  task chk(input logic [31:0] got, input logic [31:0] exp);
    #1 compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task op(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) {go, go_wr, go_addr, go_data} <= {1'b1, w, a, d};
    @(posedge ref_clk) go <= 1'b0;
    wt(3);
  endtask : op
  task pulse();
    @(posedge ref_clk) cyc <= 1'b1;
    @(posedge ref_clk) cyc <= 1'b0;
    wt(2);
  endtask : pulse
  task finish_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #200_000 bad_count++;
    finish_test();
  end
  // strap both levels, then registers, address change, faults, overcurrent
  initial begin
    for (int p = 0; p < 2; p++) begin
      // supplies held not good through both strap passes, so the stage stays hi-z
      @(posedge ref_clk) {rst, pin} <= {1'b1, p[0]};
      wt(3);
      rst <= 1'b0;
      wt(8);
      chk(bus_address, strap_addr(p[0]));
      chk(foe, 0);
      chk(hiz, 4'hF);
    end
    @(posedge ref_clk) good <= 1'b1;
    wt(8);
    chk(hiz, 0);
    op(1, FAULT_PIN_CFG_OFS, 1);
    chk({foe, fout}, 2'b11);
    op(1, OUT_MUX_CFG_OFS, 32'h01103245);
    op(1, OUT_SHDN_CFG_OFS, 32'h3A);
    chk(shdn, 32'h3A);
    chk(mux, 32'h01103245);
    op(0, OUT_MUX_CFG_OFS, 0);
    chk(rdata, 32'h01103245);
    op(0, 8'h7E, 0);
    chk(rdata, 0);
    repeat (4) begin
      v = xs();
      op(1, OUT_SHDN_CFG_OFS, v);
      op(0, OUT_SHDN_CFG_OFS, 0);
      chk(rdata, {24'h0, v[7:0]});
    end
    op(1, NEW_ADDR_OFS, v);
    op(1, ADDR_UNLOCK_OFS, 32'hF9A5A5A4);
    op(1, NEW_ADDR_OFS, v);
    chk(bus_address, strap_addr(1'b1));
    op(1, ADDR_UNLOCK_OFS, UNLOCK_PATTERN);
    op(1, NEW_ADDR_OFS, {24'h0, v[7:0]});
    chk(bus_address, v[7:1]);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) {ov, suv, auv, ot} <= 4'(1 << i);
      wt(6);
      chk(fout, 0);
      chk(hiz, 4'hF);
      op(0, FAULT_STATUS_OFS, 0);
      chk(rdata, 32'h2);
      @(posedge ref_clk) {ov, suv, auv, ot} <= 4'h0;
      wt(6);
      chk({fout, hiz}, 5'h10);
      op(1, FAULT_STATUS_OFS, xs());
      op(0, FAULT_STATUS_OFS, 0);
      chk(rdata, 0);
    end
    @(posedge ref_clk) oc <= 4'h1;
    repeat (10) pulse();
    chk({fout, hiz}, 5'h0F);
    @(posedge ref_clk) oc <= 4'h0;
    repeat (2) pulse();
    chk(hiz, 0);
    @(posedge ref_clk) {pbs, oc} <= {1'b1, 4'h2};
    wt(5);
    chk(hiz, 4'h3);
    @(posedge ref_clk) oc <= 4'h0;
    repeat (2) pulse();
    chk(hiz, 0);
    finish_test();
  end
endmodule : amp_fault_protection_ctrl_tb
